// ==== hite_pkg.sv ====
// Shared constants and types for the interrupt-enable and USB test-mode register block.
// Assumes one clock (mclk) and a synchronous active-low reset shared by both ends.
// How it works
// - Attach/detach wake flag gated by bit 7.
// - Overcurrent flag gated by bit 6.
// - Clock-stable flag gated by bit 5.
// - Bus-idle flag gated by bit 4.
// - Remote-wake flag gated by bit 3.
// - Transfer-done flag gated by bit 2.
// - Frame-start flag gated by bit 1.
// - Microframe-start flag gated by bit 0.
// - Interrupt only from set, enabled flags; write clears.
// - Software sets at most one test bit.
// - Software spaces test-register writes 150 ns apart.
// - Test bit 4 selects loopback mode.
// - Test bit 1 forces high-speed K.
// - Test bit 0 forces high-speed J.
// - Test bit 2 then test DMA sends packet.
// - Parameter registers act only in packet mode.
// - Byte count bits 24:8, reset zero, max 1023; the code stores and drives any 17-bit value unchecked.
// - Direction bit 1: 1 memory-to-FIFO, 0 reverse.
// - Go bit 0 starts the test DMA.
// - Memory start address 32 bits, reset zero.
package hite_pkg;
   localparam logic [7:0]  OFS_TEST_CTRL  = 8'h50;
   localparam logic [7:0]  OFS_XFER_PARAM = 8'h70;
   localparam logic [7:0]  OFS_XFER_BASE  = 8'h74;
   localparam logic [7:0]  OFS_IRQ_FLAGS  = 8'hA0;
   localparam logic [7:0]  OFS_IRQ_EN     = 8'hA4;
   localparam logic [7:0]  OFS_LINK_STAT  = 8'hA8;
   localparam int          IRQ_BITS       = 8;
   localparam int          TEST_LOOPBACK  = 4;
   localparam int          TEST_PACKET    = 2;
   localparam int          TEST_FORCE_K   = 1;
   localparam int          TEST_FORCE_J   = 0;
   localparam logic [31:0] TEST_CTRL_MASK = 32'h0000_0017;
   localparam int          COUNT_LSB      = 8;
   localparam int          COUNT_W        = 17;
   localparam logic [16:0] COUNT_MAX      = 17'h003FF;
   localparam int          PARAM_DIR      = 1;
   localparam int          PARAM_GO       = 0;
   localparam logic [31:0] PARAM_MASK     = 32'h01FF_FF03;
   localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
   localparam int          CLK_PERIOD_PS  = 4000;
   localparam int          WRITE_GAP_PS   = 150000;
   localparam int          WRITE_GAP_CYC  = (WRITE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   typedef enum logic [1:0] {
      LS_NORMAL   = 2'b00,
      LS_FORCE_J  = 2'b01,
      LS_FORCE_K  = 2'b10,
      LS_LOOPBACK = 2'b11
   } hite_line_t;
endpackage

// ==== hite_if.sv ====
// Register access link between the controller (host) end and the register bank (device) end.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ps
interface hite_if;
   logic        wrEn;
   logic        rdEn;
   logic [7:0]  addr;
   logic [31:0] wrData;
   logic [31:0] rdData;
   logic        rdValid;
   logic        irq;
   modport dev  (input wrEn, rdEn, addr, wrData, output rdData, rdValid, irq);
   modport host (output wrEn, rdEn, addr, wrData, input rdData, rdValid, irq);
endinterface

// ==== hite_ahb_slave.sv ====
// AHB-Lite slave front end for the controller registers.
// Assumes single word transfers and OKAY response; the owning end adds wait states.
`timescale 1ns/1ps
module hite_ahb_slave
   import hite_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   // AHB-Lite
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   // Register side
   output      logic        regWr,
   output      logic        regRdSel,
   output      logic [7:0]  regAddr
);
   import hite_pkg::*;
   typedef struct packed {
      logic       wrPend;
      logic [7:0] addr;
   } hite_slv_t;
   hite_slv_t st, next_st;
   always_comb begin
      next_st = st;
      if (clkEn && hready) begin
         next_st.wrPend = hsel && htrans[1] && hwrite;
         if (hsel && htrans[1]) begin
            next_st.addr = haddr;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign regWr     = st.wrPend && clkEn;
   assign regRdSel  = 1'b1;
   assign regAddr   = st.addr;
endmodule

// ==== hite_host.sv ====
// Controller end: software reaches its own registers over AHB-Lite and
// forwards writes and reads to the device bank across hite_if.
// Assumes the device answers a read one cycle after rdEn.
`timescale 1ns/1ps
module hite_host
   import hite_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   // AHB-Lite
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   // Device link
   hite_if.host             link
);
   import hite_pkg::*;
   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [7:0]  addr;
      logic [31:0] wrData;
      logic        rdPend;
      logic        irqSync;
      logic [7:0]  gap;
   } hite_host_t;
   hite_host_t st, next_st;
   logic       regWr;
   logic [7:0] regAddr;
   logic       mapped;
   hite_ahb_slave u_slave (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .clkEn     (clkEn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (),
      .hresp     (hresp),
      .regWr     (regWr),
      .regRdSel  (),
      .regAddr   (regAddr)
   );
   function automatic logic isTestReg(input logic [7:0] a);
      return a == OFS_TEST_CTRL || a == OFS_XFER_PARAM || a == OFS_XFER_BASE;
   endfunction
   assign mapped = isTestReg(regAddr) || regAddr == OFS_IRQ_FLAGS || regAddr == OFS_IRQ_EN;
   always_comb begin
      next_st = st;
      if (clkEn) begin
         next_st.wrEn    = 1'b0;
         next_st.rdEn    = 1'b0;
         next_st.irqSync = link.irq;
         if (st.gap != 8'h00) begin
            next_st.gap = st.gap - 8'h01;
         end
         // Read data phase ends when the bank answers
         if (link.rdValid) begin
            next_st.rdPend = 1'b0;
         end
         // Forward each mapped write; test registers then load the write-gap count shown as busy in link status
         if (regWr && mapped) begin
            next_st.wrEn   = 1'b1;
            next_st.addr   = regAddr;
            next_st.wrData = hwdata;
            if (isTestReg(regAddr)) begin
               next_st.gap = 8'(WRITE_GAP_CYC);
            end
         end else if (hsel && htrans[1] && !hwrite && hready) begin
            next_st.rdEn   = 1'b1;
            next_st.rdPend = 1'b1;
            next_st.addr   = haddr;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Link status word holds the synchronous interrupt level and write-gap busy
   always_comb begin
      if (regAddr == OFS_LINK_STAT) begin
         hrdata = {30'h0000_0000, st.gap != 8'h00, st.irqSync};
      end else begin
         hrdata = link.rdData;
      end
   end
   // Wait states while frozen or until read data stands
   assign hreadyout   = clkEn && !(st.rdPend && !link.rdValid);
   assign link.wrEn   = st.wrEn;
   assign link.rdEn   = st.rdEn;
   assign link.addr   = st.addr;
   assign link.wrData = st.wrData;
endmodule

// ==== hite_device.sv ====
// Device end: interrupt flags and enables, USB test-mode control and
// the test DMA parameter block.
// Assumes event inputs are one-cycle pulses on mclk.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module hite_device
   import hite_pkg::*;
#(
   parameter int EVENTS = IRQ_BITS
)(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              clkEn,
   // Register link
   hite_if.dev                    link,
   // Events
   input  wire logic [EVENTS-1:0] eventPulse,
   input  wire logic              highSpeed,
   input  wire logic              dmaBusy,
   // Test outputs
   output      hite_pkg::hite_line_t lineState,
   output      logic              packetMode,
   output      logic              dmaGo,
   output      logic              dmaToFifo,
   output      logic [16:0]       dmaCount,
   output      logic [31:0]       dmaAddr
);
   import hite_pkg::*;
   if (EVENTS != IRQ_BITS) begin : gBadEvents
      $error("EVENTS must equal IRQ_BITS");
   end
   typedef struct packed {
      logic [EVENTS-1:0] flags;
      logic [EVENTS-1:0] enable;
      logic [4:0]        test;
      logic [16:0]       count;
      logic              dir;
      logic              go;
      logic [31:0]       base;
      logic [31:0]       rdData;
      logic              rdValid;
      logic              irq;
   } hite_dev_t;
   hite_dev_t st, next_st;
   logic [EVENTS-1:0] clearMask;
   logic [31:0]       rdWord;
   always_comb begin
      unique case (link.addr)
         OFS_TEST_CTRL:  rdWord = {27'h0000000, st.test};
         OFS_XFER_PARAM: rdWord = {7'h00, st.count, 6'h00, st.dir, st.go};
         OFS_XFER_BASE:  rdWord = st.base;
         OFS_IRQ_FLAGS:  rdWord = {24'h000000, st.flags};
         OFS_IRQ_EN:     rdWord = {24'h000000, st.enable};
         default:        rdWord = ZERO_WORD;
      endcase
   end
   assign clearMask = (link.wrEn && link.addr == OFS_IRQ_FLAGS) ?
                      link.wrData[EVENTS-1:0] : '0;
   always_comb begin
      next_st = st;
      if (clkEn) begin
         next_st.rdValid = link.rdEn;
         next_st.rdData  = rdWord;
         next_st.go      = 1'b0;
         if (link.wrEn) begin
            unique case (link.addr)
               OFS_TEST_CTRL:  next_st.test = link.wrData[4:0] & TEST_CTRL_MASK[4:0];
               OFS_XFER_PARAM: begin
                  next_st.count = link.wrData[COUNT_LSB +: COUNT_W];
                  next_st.dir   = link.wrData[PARAM_DIR];
                  // Go only acts in packet mode and when idle
                  next_st.go    = link.wrData[PARAM_GO] && st.test[TEST_PACKET]
                                  && !dmaBusy;
               end
               OFS_XFER_BASE:  next_st.base = link.wrData;
               OFS_IRQ_EN:     next_st.enable = link.wrData[EVENTS-1:0];
               default:        next_st.test = st.test;
            endcase
         end
         // Set wins over a same-cycle clear
         next_st.flags = (st.flags & ~clearMask) | eventPulse;
         next_st.irq   = |(next_st.flags & next_st.enable);
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // One test bit expected; fixed priority if software breaks that
   always_comb begin
      if (st.test[TEST_LOOPBACK]) begin
         lineState = LS_LOOPBACK;
      end else if (st.test[TEST_FORCE_K]) begin
         lineState = LS_FORCE_K;
      end else if (st.test[TEST_FORCE_J]) begin
         lineState = LS_FORCE_J;
      end else begin
         lineState = LS_NORMAL;
      end
   end
   assign packetMode   = st.test[TEST_PACKET] && highSpeed;
   assign dmaGo        = st.go;
   assign dmaToFifo    = st.test[TEST_PACKET] && st.dir;
   assign dmaCount     = st.test[TEST_PACKET] ? st.count : 17'h00000;
   assign dmaAddr      = st.test[TEST_PACKET] ? st.base : ZERO_WORD;
   assign link.rdData  = st.rdData;
   assign link.rdValid = st.rdValid;
   assign link.irq     = st.irq;
endmodule

// ==== hite_link_properties.sv ====
// Checker on the link between the controller end and the register bank.
// Assumes one clock, synchronous active-low reset and clkEn held high.
`timescale 1ns/1ps
module hite_link_properties
   import hite_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        wrEn,
   input wire logic        rdEn,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wrData,
   input wire logic [31:0] rdData,
   input wire logic        rdValid,
   input wire logic        irq
);
   import hite_pkg::*;
   logic [7:0]  en;
   logic [31:0] ctl;
   logic [31:0] par;
   logic [31:0] base;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Shadow of the writable fields
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         en   <= 8'h00;
         ctl  <= ZERO_WORD;
         par  <= ZERO_WORD;
         base <= ZERO_WORD;
      end else if (wrEn) begin
         if (addr == OFS_IRQ_EN) en <= wrData[7:0];
         if (addr == OFS_TEST_CTRL) ctl <= wrData & TEST_CTRL_MASK;
         if (addr == OFS_XFER_PARAM) par <= wrData & PARAM_MASK & 32'hFFFF_FFFE;
         if (addr == OFS_XFER_BASE) base <= wrData;
      end
   end
   AST_READ_ANSWER: assert property (rdEn |=> rdValid)
      else $error("read not answered next cycle");
   AST_EN_READBACK: assert property (rdEn && addr == OFS_IRQ_EN |=> rdData == {24'h0, en})
      else $error("enable mask read back wrong");
   AST_CTRL_READBACK: assert property (rdEn && addr == OFS_TEST_CTRL |=> rdData == ctl)
      else $error("test control read back wrong");
   AST_PARAM_READBACK: assert property (rdEn && addr == OFS_XFER_PARAM |=> rdData == par)
      else $error("transfer parameters read back wrong");
   AST_BASE_READBACK: assert property (rdEn && addr == OFS_XFER_BASE |=> rdData == base)
      else $error("memory start read back wrong");
   AST_UNMAPPED_ZERO: assert property (rdEn && addr == 8'h3C |=> rdData == ZERO_WORD)
      else $error("unmapped read not zero");
   AST_IRQ_MASKED_OFF: assert property (wrEn && addr == OFS_IRQ_EN && wrData[7:0] == 8'h00
      |-> ##2 !irq)
      else $error("interrupt with all enables off");
   AST_IRQ_NEEDS_ENABLE: assert property ($rose(irq) |-> en != 8'h00)
      else $error("interrupt rose with no enable");
   AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> $past(wrEn))
      else $error("interrupt fell without a write");
   cover property ($rose(irq));
   cover property (rdEn && addr == OFS_XFER_PARAM);
   cover property (wrEn && addr == OFS_TEST_CTRL);
endmodule

// ==== testbench.sv ====
// Drives both ends over AHB-Lite and events; checks the link and test outputs.
// Assumes the slave may add wait states to reads; the master waits for hready.
`timescale 1ns/1ps
module testbench;
   import hite_pkg::*;
   logic mclk = 0, rst_b = 0, clkEn = 1, hsel = 0, hwrite = 0, highSpeed = 1, dmaBusy = 0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [7:0]  haddr = 8'h00, eventPulse = 8'h00;
   logic [31:0] hwdata = 32'h0, hrdata, dmaAddr;
   logic        hreadyout, packetMode, dmaGo, dmaToFifo;
   logic [16:0] dmaCount;
   hite_line_t  lineState;
   int failures = 0, compares = 0, cycles = 0, goCount = 0;
   hite_if link();
   hite_host i_hite_host (.mclk, .rst_b, .clkEn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .link(link));
   hite_device i_hite_device (.mclk, .rst_b, .clkEn, .link(link), .eventPulse, .highSpeed,
      .dmaBusy, .lineState, .packetMode, .dmaGo, .dmaToFifo, .dmaCount, .dmaAddr);
   hite_link_properties i_hite_link_properties (.mclk, .rst_b, .wrEn(link.wrEn),
      .rdEn(link.rdEn), .addr(link.addr), .wrData(link.wrData), .rdData(link.rdData),
      .rdValid(link.rdValid), .irq(link.irq));
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (dmaGo === 1'b1) goCount <= goCount + 1;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end
   function automatic logic expIrq(logic [7:0] en, logic [7:0] ev);
      return |(en & ev);
   endfunction
   function automatic hite_line_t expLine(int m);
      return m == TEST_FORCE_J ? LS_FORCE_J : m == TEST_FORCE_K ? LS_FORCE_K :
             m == TEST_LOOPBACK ? LS_LOOPBACK : LS_NORMAL;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
      repeat (WRITE_GAP_CYC) @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      ahb(1'b0, a, ZERO_WORD, r);
   endtask
   task automatic trial(input logic [7:0] en, input logic [7:0] ev);
      logic [31:0] r;
      wr(OFS_IRQ_FLAGS, 32'h0000_00FF);
      chk("irq cleared", ZERO_WORD, 32'(link.irq));
      eventPulse <= ev;
      @(posedge mclk);
      eventPulse <= 8'h00;
      repeat (3) @(posedge mclk);
      chk("irq", 32'(expIrq(en, ev)), 32'(link.irq));
      rd(OFS_LINK_STAT, r);
      chk("link status", 32'(expIrq(en, ev)), r);
      rd(OFS_IRQ_FLAGS, r);
      chk("event flags", 32'(ev), r);
   endtask
   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      logic [31:0] r, d, b;
      logic [7:0]  en;
      logic [7:0]  regs[4] = '{OFS_IRQ_EN, OFS_TEST_CTRL, OFS_XFER_PARAM, OFS_XFER_BASE};
      int          modes[4] = '{TEST_FORCE_J, TEST_FORCE_K, TEST_LOOPBACK, TEST_PACKET};
      int          g;
      logic        pk;
      void'($urandom(32'h9c6c9220));
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (regs[i]) begin
         rd(regs[i], r);
         chk("reset value", ZERO_WORD, r);
      end
      rd(8'h3C, r);
      chk("unmapped", ZERO_WORD, r);
      for (int k = 0; k < 14; k++) begin
         en = (k < 8) ? 8'h01 << k : (k == 8 ? 8'h00 : 8'($urandom));
         wr(OFS_IRQ_EN, 32'(en) | 32'hFFFF_FF00);
         rd(OFS_IRQ_EN, r);
         chk("irq enable", 32'(en), r);
         trial(en, en & 8'hF0);
         trial(en, ~en & 8'hF0);
         trial(en, en & 8'h0F);
         trial(en, ~en & 8'h0F);
      end
      foreach (modes[i]) begin
         wr(OFS_TEST_CTRL, 32'hFFFF_FFE8 | (32'h1 << modes[i]));
         chk("line", 32'(expLine(modes[i])), 32'(lineState));
         chk("packet mode", 32'(modes[i] == TEST_PACKET), 32'(packetMode));
         highSpeed <= 1'b0;
         @(posedge mclk);
         chk("packet mode slow", ZERO_WORD, 32'(packetMode));
         highSpeed <= 1'b1;
         rd(OFS_TEST_CTRL, r);
         chk("test control", 32'h1 << modes[i], r);
      end
      for (int k = 0; k < 6; k++) begin
         pk = (k < 3);
         b = $urandom;
         d = {7'h7F, 17'(k == 0 ? 1023 : $urandom_range(1023)), 6'h3F, 1'($urandom), 1'b1};
         wr(OFS_XFER_BASE, b);
         dmaBusy <= (k == 1);
         g = goCount;
         wr(OFS_XFER_PARAM, d);
         chk("go pulses", 32'(pk && k != 1), 32'(goCount - g));
         chk("count", pk ? 32'(d[24:8]) : ZERO_WORD, 32'(dmaCount));
         chk("mem start", pk ? b : ZERO_WORD, dmaAddr);
         if (pk) chk("direction", 32'(d[1]), 32'(dmaToFifo));
         rd(OFS_XFER_PARAM, r);
         chk("params", d & 32'h01FF_FF02, r);
         rd(OFS_XFER_BASE, r);
         chk("mem base", b, r);
         if (k == 2) wr(OFS_TEST_CTRL, ZERO_WORD);
      end
      test_done();
   end
endmodule
